// >>> dic_consts.svh
// constants for the drive input conditioning block
`ifndef DIC_CONSTS_SVH
`define DIC_CONSTS_SVH
`define DIC_FULL 12'hfff
`define DIC_FOUR_MA 12'h333
`define DIC_VRANGE_FULL 1'b0
`define DIC_IRANGE_0_20 2'h0
`define DIC_IRANGE_4_20 2'h1
`define DIC_IRANGE_CUSTOM 2'h2
`define DIC_FN_ACC_SEL 4'h4
`define DIC_FN_REVERSE 4'h5
`define DIC_FN_FREEZE 4'h8
`define DIC_FN_DC_BRAKE 4'h9
`define DIC_FN_POT_UP 4'h4
`define DIC_FN_POT_DOWN 4'ha
`define DIC_SP_VOLT 3'h0
`define DIC_SP_CURR 3'h1
`define DIC_SP_PANEL 3'h2
`define DIC_SP_POT 3'h3
`define DIC_SP_POT_RST 3'h4
`define DIC_PLACE_POT_A 3'h3
`define DIC_PLACE_POT_B 3'h4
`define DIC_CLK_NS 5
`define DIC_FILT_SUB_NS 62500
`define DIC_FILT_SUB_CYC (`DIC_FILT_SUB_NS / `DIC_CLK_NS)
`define DIC_FILT_SHIFT 4
`define DIC_RAMP_STEP_NS 244
`define DIC_RAMP_STEP_CYC (`DIC_RAMP_STEP_NS / `DIC_CLK_NS)
`endif

// >>> dic_pkg.sv
// types and shared arithmetic of the drive input conditioning block
package dic_pkg;
   typedef logic [11:0] dic_level_t;

   typedef struct packed {
      logic [13:0] sub;
      logic [15:0] cnt;
      logic [15:0] y;
   } dic_filt_s;

   typedef struct packed {
      logic [5:0] sub;
      logic [15:0] cnt;
      dic_level_t val;
   } dic_ramp_s;

   typedef struct packed {
      dic_level_t vmin;
      dic_level_t vmax;
      dic_level_t imin;
      dic_level_t imax;
      dic_level_t setpoint;
      dic_level_t act1;
      dic_level_t act2;
      logic signed [12:0] err;
      logic rev;
      logic acc2;
      logic hold;
      logic dcbrk;
      logic run_prev;
   } dic_main_s;

   // maps lo..hi onto 0..full scale, clamped; an empty span passes through
   function automatic dic_level_t dic_rescale(input dic_level_t x, input dic_level_t lo,
                                              input dic_level_t hi);
      logic [23:0] num;
      logic [23:0] den;
      num = 24'(x - lo) * 24'hfff;
      den = 24'(hi - lo);
      if (hi <= lo) begin
         dic_rescale = x;
      end else if (x <= lo) begin
         dic_rescale = 12'h000;
      end else if (x >= hi) begin
         dic_rescale = 12'hfff;
      end else begin
         dic_rescale = 12'(num / den);
      end
   endfunction : dic_rescale
endpackage : dic_pkg

// >>> dic_scale.sv
// analog input path: span scaling, inversion and first-order filter
`timescale 1ns/1ps
`include "dic_consts.svh"
module dic_scale #(
   parameter int FILT_SUB_CYC = `DIC_FILT_SUB_CYC
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [11:0] raw_i,
   input wire logic [11:0] lo_i,
   input wire logic [11:0] hi_i,
   input wire logic invert_i,
   input wire logic [15:0] filt_time_i,
   output logic [11:0] level_o
);
   dic_pkg::dic_filt_s st_r;
   dic_pkg::dic_filt_s st_nxt;
   dic_pkg::dic_level_t scaled;
   logic signed [16:0] diff;

   always_comb begin
      scaled = dic_pkg::dic_rescale(raw_i, lo_i, hi_i);
      if (invert_i) begin
         scaled = `DIC_FULL - scaled;
      end
      diff = $signed({1'b0, scaled, 4'h0}) - $signed({1'b0, st_r.y});
      st_nxt = st_r;
      // y moves 1/16 of the gap per filt_time sub-ticks: tau equals filt_time ms
      if (filt_time_i == 16'h0000) begin
         st_nxt.y = {scaled, 4'h0};
         st_nxt.sub = 14'h0000;
         st_nxt.cnt = 16'h0000;
      end else if (st_r.sub == 14'(FILT_SUB_CYC - 1)) begin
         st_nxt.sub = 14'h0000;
         if (st_r.cnt + 16'h0001 >= filt_time_i) begin
            st_nxt.cnt = 16'h0000;
            st_nxt.y = 16'($signed({1'b0, st_r.y})
               + (diff >>> `DIC_FILT_SHIFT));
         end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
         end
      end else begin
         st_nxt.sub = st_r.sub + 14'h0001;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level_o = st_r.y[15:4];

   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   a_filter_bypass: assert property (
      (filt_time_i == 16'h0000) |=> level_o == $past(scaled))
      else $error("unfiltered level does not follow input");
   a_filter_hold: assert property (
      (filt_time_i != 16'h0000 && st_r.sub != 14'(FILT_SUB_CYC - 1)
      && $stable(filt_time_i)) |=> $stable(level_o))
      else $error("filtered level moved between updates");
endmodule : dic_scale

// >>> dic_ramp.sv
// motor potentiometer reference ramp
`timescale 1ns/1ps
`include "dic_consts.svh"
module dic_ramp (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic up_i,
   input wire logic down_i,
   input wire logic [15:0] ramp_time_i,
   input wire logic reload_i,
   input wire logic [11:0] reload_val_i,
   output logic [11:0] value_o
);
   dic_pkg::dic_ramp_s st_r;
   dic_pkg::dic_ramp_s st_nxt;
   logic step;

   always_comb begin
      st_nxt = st_r;
      step = 1'b0;
      if (st_r.sub == 6'(`DIC_RAMP_STEP_CYC - 1)) begin
         st_nxt.sub = 6'h00;
         // one lsb per ramp_time sub-steps: full scale in about ramp_time ms
         if (st_r.cnt + 16'h0001 >= ramp_time_i) begin
            st_nxt.cnt = 16'h0000;
            step = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
         end
      end else begin
         st_nxt.sub = st_r.sub + 6'h01;
      end
      // reload wins over both contacts; both closed holds the value
      if (reload_i) begin
         st_nxt.val = reload_val_i;
      end else if (step && up_i && !down_i && st_r.val != `DIC_FULL) begin
         st_nxt.val = st_r.val + 12'h001;
      end else if (step && down_i && !up_i && st_r.val != 12'h000) begin
         st_nxt.val = st_r.val - 12'h001;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign value_o = st_r.val;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   a_pot_no_drift: assert property (
      (!up_i && !down_i && !reload_i) |=> $stable(value_o))
      else $error("pot value moved with no contact closed");
endmodule : dic_ramp

// >>> dic_top.sv
// drive input conditioning: analog inputs, contact decode, pi setpoint and error
`timescale 1ns/1ps
`include "dic_consts.svh"
module dic_top #(
   parameter int FILT_SUB_CYC = `DIC_FILT_SUB_CYC
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [11:0] voltage_analog_input_i,
   input wire logic [11:0] current_analog_input_i,
   input wire logic reference_up_contact_i,
   input wire logic reference_down_contact_i,
   input wire logic multi_function_contact_i,
   input wire logic run_i,
   input wire logic v_range_i,
   input wire logic capture_v_min_i,
   input wire logic capture_v_max_i,
   input wire logic v_invert_i,
   input wire logic [15:0] v_filt_time_i,
   input wire logic [1:0] i_range_i,
   input wire logic capture_i_min_i,
   input wire logic capture_i_max_i,
   input wire logic i_invert_i,
   input wire logic [15:0] i_filt_time_i,
   input wire logic [3:0] up_fn_i,
   input wire logic [3:0] down_fn_i,
   input wire logic [3:0] multi_fn_i,
   input wire logic [2:0] control_place_i,
   input wire logic [15:0] pot_ramp_time_i,
   input wire logic [2:0] setpoint_sel_i,
   input wire logic [11:0] panel_pi_setpoint_i,
   input wire logic [11:0] min_freq_i,
   input wire logic [11:0] actual1_i,
   input wire logic [11:0] actual2_i,
   input wire logic [11:0] act1_min_i,
   input wire logic [11:0] act1_max_i,
   input wire logic [11:0] act2_min_i,
   input wire logic [11:0] act2_max_i,
   input wire logic actual_sel_i,
   input wire logic error_invert_i,
   output logic [11:0] voltage_level_o,
   output logic [11:0] current_level_o,
   output logic [11:0] setpoint_o,
   output logic [11:0] actual1_o,
   output logic [11:0] actual2_o,
   output logic signed [12:0] pi_error_o,
   output logic reverse_o,
   output logic acc_dec_sel2_o,
   output logic ramp_hold_o,
   output logic dc_brake_o
);
   dic_pkg::dic_main_s st_r;
   dic_pkg::dic_main_s st_nxt;
   dic_pkg::dic_level_t v_lo;
   dic_pkg::dic_level_t v_hi;
   dic_pkg::dic_level_t i_lo;
   dic_pkg::dic_level_t i_hi;
   dic_pkg::dic_level_t pot_val;
   dic_pkg::dic_level_t act_sel;
   logic [3:0] up_fn_eff;
   logic [3:0] down_fn_eff;
   logic pot_mode;
   logic pot_up;
   logic pot_down;
   logic pot_reload;
   logic signed [12:0] err_raw;

   // span selection for the two analog inputs
   always_comb begin
      if (v_range_i == `DIC_VRANGE_FULL) begin
         v_lo = 12'h000;
         v_hi = `DIC_FULL;
      end else begin
         v_lo = st_r.vmin;
         v_hi = st_r.vmax;
      end
      unique case (i_range_i)
         `DIC_IRANGE_0_20: begin
            i_lo = 12'h000;
            i_hi = `DIC_FULL;
         end
         `DIC_IRANGE_4_20: begin
            i_lo = `DIC_FOUR_MA;
            i_hi = `DIC_FULL;
         end
         `DIC_IRANGE_CUSTOM: begin
            i_lo = st_r.imin;
            i_hi = st_r.imax;
         end
         default: begin
            i_lo = 12'h000;
            i_hi = `DIC_FULL;
         end
      endcase
   end

   dic_scale #(
      .FILT_SUB_CYC(FILT_SUB_CYC)
   ) u_volt (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .raw_i(voltage_analog_input_i),
      .lo_i(v_lo),
      .hi_i(v_hi),
      .invert_i(v_invert_i),
      .filt_time_i(v_filt_time_i),
      .level_o(voltage_level_o)
   );

   dic_scale #(
      .FILT_SUB_CYC(FILT_SUB_CYC)
   ) u_curr (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .raw_i(current_analog_input_i),
      .lo_i(i_lo),
      .hi_i(i_hi),
      .invert_i(i_invert_i),
      .filt_time_i(i_filt_time_i),
      .level_o(current_level_o)
   );

   // contact function decode; pot control places override the programmed up and down codes
   always_comb begin
      pot_mode = (control_place_i == `DIC_PLACE_POT_A) || (control_place_i == `DIC_PLACE_POT_B);
      up_fn_eff = pot_mode ? `DIC_FN_POT_UP : up_fn_i;
      down_fn_eff = pot_mode ? `DIC_FN_POT_DOWN : down_fn_i;
      pot_up = reference_up_contact_i && (up_fn_eff == `DIC_FN_POT_UP);
      pot_down = reference_down_contact_i && (down_fn_eff == `DIC_FN_POT_DOWN);
      pot_reload = (setpoint_sel_i == `DIC_SP_POT_RST) && st_r.run_prev && !run_i;
   end

   dic_ramp u_pot (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .up_i(pot_up),
      .down_i(pot_down),
      .ramp_time_i(pot_ramp_time_i),
      .reload_i(pot_reload),
      .reload_val_i(min_freq_i),
      .value_o(pot_val)
   );

   always_comb begin
      act_sel = actual_sel_i ? st_r.act2 : st_r.act1;
      err_raw = $signed({1'b0, st_r.setpoint}) - $signed({1'b0, act_sel});
      st_nxt = st_r;
      st_nxt.run_prev = run_i;
      // live level captured on enter; no other path writes these limits
      if (capture_v_min_i) begin
         st_nxt.vmin = voltage_analog_input_i;
      end
      if (capture_v_max_i) begin
         st_nxt.vmax = voltage_analog_input_i;
      end
      if (capture_i_min_i) begin
         st_nxt.imin = current_analog_input_i;
      end
      if (capture_i_max_i) begin
         st_nxt.imax = current_analog_input_i;
      end
      unique case (setpoint_sel_i)
         `DIC_SP_VOLT: st_nxt.setpoint = voltage_level_o;
         `DIC_SP_CURR: st_nxt.setpoint = current_level_o;
         `DIC_SP_PANEL: st_nxt.setpoint = panel_pi_setpoint_i;
         `DIC_SP_POT: st_nxt.setpoint = pot_val;
         `DIC_SP_POT_RST: st_nxt.setpoint = pot_val;
         default: st_nxt.setpoint = st_r.setpoint;
      endcase
      st_nxt.act1 = dic_pkg::dic_rescale(actual1_i, act1_min_i, act1_max_i);
      st_nxt.act2 = dic_pkg::dic_rescale(actual2_i, act2_min_i, act2_max_i);
      st_nxt.err = error_invert_i ? -err_raw : err_raw;
      // one closed reverse contact is enough, so the two sources are or-ed
      st_nxt.rev = (multi_function_contact_i && multi_fn_i == `DIC_FN_REVERSE)
         || (reference_down_contact_i && down_fn_eff == `DIC_FN_REVERSE);
      st_nxt.acc2 = (multi_function_contact_i && multi_fn_i == `DIC_FN_ACC_SEL)
         || (reference_down_contact_i && down_fn_eff == `DIC_FN_ACC_SEL);
      st_nxt.hold = (multi_function_contact_i && multi_fn_i == `DIC_FN_FREEZE)
         || (reference_down_contact_i && down_fn_eff == `DIC_FN_FREEZE);
      // braking only while stopped; the braking current is set elsewhere
      st_nxt.dcbrk = !run_i && ((multi_function_contact_i && multi_fn_i == `DIC_FN_DC_BRAKE)
         || (reference_down_contact_i && down_fn_eff == `DIC_FN_DC_BRAKE));
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign setpoint_o = st_r.setpoint;
   assign actual1_o = st_r.act1;
   assign actual2_o = st_r.act2;
   assign pi_error_o = st_r.err;
   assign reverse_o = st_r.rev;
   assign acc_dec_sel2_o = st_r.acc2;
   assign ramp_hold_o = st_r.hold;
   assign dc_brake_o = st_r.dcbrk;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   // contact decodes answer one cycle after the edge that sees the contact
   a_reverse_any: assert property (
      (multi_function_contact_i && multi_fn_i == `DIC_FN_REVERSE) |=> reverse_o)
      else $error("closed reverse contact did not select reverse");
   a_forward_open: assert property (
      (!multi_function_contact_i && !reference_down_contact_i) |=> !reverse_o)
      else $error("reverse with every contact open");
   a_acc_select: assert property (
      (multi_fn_i == `DIC_FN_ACC_SEL && down_fn_eff != `DIC_FN_ACC_SEL)
      |=> acc_dec_sel2_o == $past(multi_function_contact_i))
      else $error("ramp time select does not follow contact");
   a_acc_open: assert property (
      (!multi_function_contact_i && !reference_down_contact_i) |=> !acc_dec_sel2_o)
      else $error("ramp time 2 with every contact open");
   a_ramp_freeze: assert property (
      (multi_function_contact_i && multi_fn_i == `DIC_FN_FREEZE) |=> ramp_hold_o)
      else $error("closed freeze contact did not hold the ramp");
   a_freeze_open: assert property (
      (!multi_function_contact_i && !reference_down_contact_i) |=> !ramp_hold_o)
      else $error("ramp held with every contact open");
   a_dc_brake: assert property (
      (multi_function_contact_i && multi_fn_i == `DIC_FN_DC_BRAKE && !run_i) |=> dc_brake_o)
      else $error("stopped drive with brake contact is not braking");
   a_brake_running: assert property (
      run_i |=> !dc_brake_o)
      else $error("dc braking while running");
   a_brake_open: assert property (
      (!multi_function_contact_i && !reference_down_contact_i) |=> !dc_brake_o)
      else $error("dc braking with every contact open");
   // setpoint follows the chosen source one cycle later
   a_volt_setpoint: assert property (
      (setpoint_sel_i == `DIC_SP_VOLT) |=> setpoint_o == $past(voltage_level_o))
      else $error("voltage setpoint not taken");
   a_curr_setpoint: assert property (
      (setpoint_sel_i == `DIC_SP_CURR) |=> setpoint_o == $past(current_level_o))
      else $error("current setpoint not taken");
   a_panel_setpoint: assert property (
      (setpoint_sel_i == `DIC_SP_PANEL) |=> setpoint_o == $past(panel_pi_setpoint_i))
      else $error("panel setpoint not taken");
   a_pot_setpoint: assert property (
      (setpoint_sel_i == `DIC_SP_POT) |=> setpoint_o == $past(pot_val))
      else $error("pot setpoint not taken");
   a_pot_reload: assert property (
      (setpoint_sel_i == `DIC_SP_POT_RST && run_i ##1 !run_i)
      ##1 (setpoint_sel_i == `DIC_SP_POT_RST) |=> setpoint_o == $past(min_freq_i, 2))
      else $error("pot reference not reloaded at stop");
   a_pot_down: assert property (
      (pot_down && !pot_up && !pot_reload) |=> pot_val <= $past(pot_val))
      else $error("pot reference rose while lowering");
   a_pot_up: assert property (
      (pot_up && !pot_down && !pot_reload) |=> pot_val >= $past(pot_val))
      else $error("pot reference fell while raising");
   a_pot_fn_off: assert property (
      (!pot_mode && up_fn_i != `DIC_FN_POT_UP) |-> !pot_up)
      else $error("up contact ramps the pot without the pot function");
   // pot control places override whatever up and down codes are programmed
   a_place_force: assert property (
      (pot_mode && reference_down_contact_i && down_fn_i != `DIC_FN_POT_DOWN) |-> pot_down)
      else $error("pot control place did not force the down function");
   a_place_force_up: assert property (
      (pot_mode && reference_up_contact_i && up_fn_i != `DIC_FN_POT_UP) |-> pot_up)
      else $error("pot control place did not force the up function");
   a_vmin_capture: assert property (
      !capture_v_min_i |=> st_r.vmin == $past(st_r.vmin))
      else $error("custom voltage minimum changed without capture");
   a_imax_capture: assert property (
      capture_i_max_i |=> st_r.imax == $past(current_analog_input_i))
      else $error("custom current maximum not captured");
   a_err_invert: assert property (
      1'b1 |=> pi_error_o == ($past(error_invert_i) ? -$past(err_raw) : $past(err_raw)))
      else $error("pi error sign wrong");

   c_reverse: cover property (multi_function_contact_i && multi_fn_i == `DIC_FN_REVERSE
      ##1 reverse_o);
   c_pot_reload: cover property (setpoint_sel_i == `DIC_SP_POT_RST && pot_reload);
   c_brake: cover property (dc_brake_o ##1 !dc_brake_o);
   c_err_inverted: cover property (error_invert_i ##1 pi_error_o != 13'h0000);
   c_pot_forced: cover property (pot_mode && pot_down && down_fn_i != `DIC_FN_POT_DOWN);
endmodule : dic_top

// >>> dic_field.sv
// field wiring model: potentiometer, current transducer and contacts
`timescale 1ns/1ps
module dic_field (
   input wire logic clk_i,
   input wire logic [11:0] pot_set_i,
   input wire logic [11:0] ma_set_i,
   input wire logic [2:0] close_i,
   output logic [11:0] volt_o,
   output logic [11:0] curr_o,
   output logic up_o,
   output logic down_o,
   output logic multi_o
);
   // one clock of wiring delay; a level stays where the operator left it
   always_ff @(posedge clk_i) begin
      volt_o <= pot_set_i;
      curr_o <= ma_set_i;
      {up_o, down_o, multi_o} <= close_i;
   end
endmodule : dic_field

// >>> drive_input_conditioning_test.sv
// self-checking bench of the drive input conditioning block
`timescale 1ns/1ps
module drive_input_conditioning_test;
   logic clk, rst_n = 1'b0, run = 1'b0, v_range = 1'b0, cvmin = 1'b0, cvmax = 1'b0;
   logic v_inv = 1'b0, cimin = 1'b0, cimax = 1'b0, i_inv = 1'b0, a_sel = 1'b0, e_inv = 1'b0;
   logic [2:0] close = 3'h0, place = 3'h0, sp_sel = 3'h0;
   logic [1:0] i_range = 2'h0;
   logic [3:0] up_fn = 4'h0, down_fn = 4'h0, multi_fn = 4'h0;
   logic [15:0] v_ft = 16'h0000, i_ft = 16'h0000, ramp = 16'h0001;
   logic [11:0] pot_set = 12'h000, ma_set = 12'h000, panel = 12'h000, min_freq = 12'h000;
   logic [11:0] act1 = 12'h000, act2 = 12'h000, a1min = 12'h000, a1max = 12'h000;
   logic [11:0] a2min = 12'h000, a2max = 12'h000;
   logic [11:0] volt, curr, vlev, ilev, sp, ao1, ao2, e, a;
   logic up_c, down_c, multi_c, rev, acc2, hold, brk;
   logic signed [12:0] perr, ee;
   logic [31:0] seed = 32'ha5cf;
   logic [31:0] r;
   logic [3:0] fns [4] = '{4'h4, 4'h5, 4'h8, 4'h9};
   int n_mismatch = 0;
   int checks = 0;

   dic_field u_dic_field (.clk_i(clk), .pot_set_i(pot_set), .ma_set_i(ma_set),
      .close_i(close), .volt_o(volt), .curr_o(curr), .up_o(up_c), .down_o(down_c),
      .multi_o(multi_c));

   // short filter sub-tick keeps the run brief
   dic_top #(.FILT_SUB_CYC(4)) u_dic_top (.clk_i(clk), .reset_n_i(rst_n),
      .voltage_analog_input_i(volt), .current_analog_input_i(curr),
      .reference_up_contact_i(up_c), .reference_down_contact_i(down_c),
      .multi_function_contact_i(multi_c), .run_i(run), .v_range_i(v_range),
      .capture_v_min_i(cvmin), .capture_v_max_i(cvmax), .v_invert_i(v_inv),
      .v_filt_time_i(v_ft), .i_range_i(i_range), .capture_i_min_i(cimin),
      .capture_i_max_i(cimax), .i_invert_i(i_inv), .i_filt_time_i(i_ft),
      .up_fn_i(up_fn), .down_fn_i(down_fn), .multi_fn_i(multi_fn),
      .control_place_i(place), .pot_ramp_time_i(ramp), .setpoint_sel_i(sp_sel),
      .panel_pi_setpoint_i(panel), .min_freq_i(min_freq), .actual1_i(act1),
      .actual2_i(act2), .act1_min_i(a1min), .act1_max_i(a1max), .act2_min_i(a2min),
      .act2_max_i(a2max), .actual_sel_i(a_sel), .error_invert_i(e_inv),
      .voltage_level_o(vlev), .current_level_o(ilev), .setpoint_o(sp), .actual1_o(ao1),
      .actual2_o(ao2), .pi_error_o(perr), .reverse_o(rev), .acc_dec_sel2_o(acc2),
      .ramp_hold_o(hold), .dc_brake_o(brk));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // independent span model: clamp outside, pass through on an empty span
   function automatic logic [11:0] exp_scale(input logic [11:0] x, lo, hi);
      logic [23:0] d;
      if (hi <= lo) return x;
      if (x <= lo) return 12'h000;
      if (x >= hi) return 12'hfff;
      d = 24'(x - lo) * 24'hfff;
      return 12'(d / 24'(hi - lo));
   endfunction : exp_scale

   task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic final_report();
      if (n_mismatch == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report

   initial begin
      #200000;
      n_mismatch++;
      final_report();
   end

   initial begin
      tick(12);
      rst_n <= 1'b1;
      tick(2);
      for (int k = 0; k < 8; k++) begin
         r = rnd();
         pot_set <= r[11:0];
         v_inv <= r[12];
         tick(6);
         e = r[12] ? 12'hfff - r[11:0] : r[11:0];
         chk(13'(vlev), 13'(e));
         chk(13'(sp), 13'(e));
      end
      // limits come only from live captures
      v_inv <= 1'b0;
      pot_set <= 12'h200;
      tick(4);
      cvmin <= 1'b1;
      tick(1);
      cvmin <= 1'b0;
      pot_set <= 12'he00;
      tick(4);
      cvmax <= 1'b1;
      tick(1);
      cvmax <= 1'b0;
      v_range <= 1'b1;
      for (int k = 0; k < 6; k++) begin
         r = rnd();
         e = (k == 0) ? 12'h100 : r[11:0];
         pot_set <= e;
         tick(6);
         chk(13'(vlev), 13'(exp_scale(e, 12'h200, 12'he00)));
      end
      ma_set <= 12'h100;
      tick(4);
      cimin <= 1'b1;
      tick(1);
      cimin <= 1'b0;
      ma_set <= 12'h800;
      tick(4);
      cimax <= 1'b1;
      tick(1);
      cimax <= 1'b0;
      sp_sel <= 3'h1;
      for (int k = 0; k < 6; k++) begin
         r = rnd();
         i_range <= 2'(k % 3);
         i_inv <= (k > 3);
         ma_set <= r[11:0];
         tick(6);
         e = (k % 3 == 0) ? r[11:0] : (k % 3 == 1) ? exp_scale(r[11:0], 12'h333, 12'hfff)
            : exp_scale(r[11:0], 12'h100, 12'h800);
         // inverted current path reads full scale minus the level
         if (k > 3) begin
            e = 12'hfff - e;
         end
         chk(13'(ilev), 13'(e));
         chk(13'(sp), 13'(e));
      end
      for (int k = 0; k < 4; k++) begin
         multi_fn <= fns[k];
         close <= 3'b001;
         tick(4);
         chk(13'({acc2, rev, hold, brk}), 13'(4'b1000 >> k));
         close <= 3'b000;
         tick(4);
         chk(13'({acc2, rev, hold, brk}), 13'h0);
      end
      multi_fn <= 4'h9;
      close <= 3'b001;
      run <= 1'b1;
      tick(4);
      chk(13'(brk), 13'h0);
      multi_fn <= 4'h5;
      down_fn <= 4'h5;
      close <= 3'b010;
      tick(4);
      chk(13'(rev), 13'h1);
      place <= 3'h3;
      tick(4);
      chk(13'(rev), 13'h0);
      // pot mode with plain codes: forced functions must still move it
      down_fn <= 4'h0;
      close <= 3'b000;
      sp_sel <= 3'h4;
      min_freq <= 12'h100;
      tick(4);
      run <= 1'b0;
      tick(4);
      chk(13'(sp), 13'h100);
      close <= 3'b100;
      tick(480);
      close <= 3'b000;
      tick(4);
      chk(13'(sp >= 12'h109 && sp <= 12'h10b), 13'h1);
      run <= 1'b1;
      tick(4);
      run <= 1'b0;
      ramp <= 16'h0002;
      tick(4);
      chk(13'(sp), 13'h100);
      close <= 3'b010;
      tick(480);
      close <= 3'b000;
      tick(4);
      chk(13'(sp >= 12'h0fa && sp <= 12'h0fc), 13'h1);
      // plain pot source keeps its value across a stop
      sp_sel <= 3'h3;
      run <= 1'b1;
      tick(4);
      run <= 1'b0;
      tick(4);
      chk(13'(sp >= 12'h0fa && sp <= 12'h0fc), 13'h1);
      place <= 3'h0;
      sp_sel <= 3'h2;
      a1min <= 12'h100;
      a1max <= 12'h900;
      a2max <= 12'h800;
      for (int k = 0; k < 4; k++) begin
         r = rnd();
         panel <= r[11:0];
         act1 <= r[23:12];
         act2 <= r[31:20];
         a_sel <= k[0];
         e_inv <= k[1];
         tick(6);
         a = k[0] ? exp_scale(r[31:20], 12'h000, 12'h800) : exp_scale(r[23:12], 12'h100, 12'h900);
         ee = 13'(r[11:0]) - 13'(a);
         chk(13'(ao1), 13'(exp_scale(r[23:12], 12'h100, 12'h900)));
         chk(13'(ao2), 13'(exp_scale(r[31:20], 12'h000, 12'h800)));
         chk(perr, k[1] ? -ee : ee);
      end
      // step response through the first-order filter
      v_range <= 1'b0;
      pot_set <= 12'h000;
      tick(6);
      v_ft <= 16'h0001;
      pot_set <= 12'hfff;
      tick(12);
      chk(13'(vlev < 12'h400), 13'h1);
      tick(28);
      chk(13'(vlev > 12'h300 && vlev < 12'ha00), 13'h1);
      tick(2000);
      chk(13'(vlev > 12'hf00), 13'h1);
      final_report();
   end
endmodule : drive_input_conditioning_test
